// *** core/pdct_params.svh ***
// timing counts and reset values for the classification event tracker
// assumes a 250 MHz ref_clk; included by the tracker and its input filter
`ifndef PDCT_PARAMS_SVH
`define PDCT_PARAMS_SVH
`define PDCT_CLK_MHZ        250
`define PDCT_UV_FILT_US     10
`define PDCT_UV_FILT_CYC    (`PDCT_UV_FILT_US * `PDCT_CLK_MHZ)
`define PDCT_EVT_FILT_NS    200
`define PDCT_EVT_FILT_CYC   ((`PDCT_EVT_FILT_NS * `PDCT_CLK_MHZ) / 1000)
`define PDCT_FINGERS_NEEDED 2
`define PDCT_CNT_W          16
`define PDCT_IND_RESET      1'b1
`endif

// *** core/pdct_pkg.sv ***
// types shared by the classification event tracker files
package pdct_pkg;
   typedef enum logic [2:0] {
      PDCT_IDLE   = 3'b000,
      PDCT_FINGER = 3'b001,
      PDCT_MARK   = 3'b011,
      PDCT_DONE   = 3'b010,
      PDCT_FAIL   = 3'b110
   } pdct_state_e;
   typedef logic [1:0] pdct_cnt_t;
endpackage

// *** core/pdct_sync_if.sv ***
// carries qualified levels from the input filter to the tracker
// assumes one clock domain
`timescale 1ns/10ps
interface pdct_sync_if;
   logic uvlo_on;
   logic det_exit;
   logic cls;
   logic mark;
   logic rst_rng;
   modport src (output uvlo_on, det_exit, cls, mark, rst_rng);
   modport dst (input  uvlo_on, det_exit, cls, mark, rst_rng);
endinterface

// *** core/pdct_filter.sv ***
// synchronises and debounces one comparator level
// assumes asynchronous comparator output, ref_clk domain
`timescale 1ns/10ps
`include "pdct_params.svh"
module pdct_filter #(
   parameter int CYC = 4
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic raw,
   output logic      q
);
   logic                  s1_reg;
   logic                  s2_reg;
   logic [`PDCT_CNT_W-1:0] cnt_reg;
   always_ff @(posedge ref_clk) begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
   end
   // level must stand CYC cycles before it is believed
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_reg <= 16'h0000;
         q       <= 1'b0;
      end else if (s2_reg == q) begin
         cnt_reg <= 16'h0000;
      end else if (cnt_reg >= CYC[`PDCT_CNT_W-1:0] - 16'h0001) begin
         cnt_reg <= 16'h0000;
         q       <= s2_reg;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
endmodule

// *** core/pdct_tracker.sv ***
// PoE powered-device classification event tracker
// assumes raw comparator levels from the analog front end
//
// Contract
// - run above turn-on, stop below turn-off
// - filter turn-on/off decisions against brief drops
// - enable bias at detection-exit level
// - grant only after finger,mark,finger,mark
// - extra fingers give two-finger outcome
// - drive indicator low when granted and powered
// - otherwise leave indicator released
// - released when classification skipped
// - released after single-event classification
// - dropping into reset range invalidates the sequence
// - enter operating mode at turn-on, with or without handshake
`timescale 1ns/10ps
`include "pdct_params.svh"
module pdct_tracker
   import pdct_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic uvlo_on_raw,
   input  wire logic det_exit_raw,
   input  wire logic class_range_raw,
   input  wire logic mark_range_raw,
   input  wire logic reset_range_raw,
   input  wire logic converter_power_good,
   output logic      operating,
   output logic      bias_enable,
   output logic      high_power_grant_indicator_n_o,
   output logic      high_power_grant_indicator_n_oe
);
   import pdct_pkg::*;

   pdct_sync_if sif ();
   pdct_state_e state_reg;
   pdct_cnt_t   fingers_reg;
   logic        pg_s1_reg;
   logic        pg_s2_reg;

   //////////////////////////////////////////////////////////////////////
   // input qualification; turn-on uses long filter, hysteresis is analog
   pdct_filter #(.CYC(`PDCT_UV_FILT_CYC)) u_uv (
      .ref_clk (ref_clk),
      .rst     (rst),
      .raw     (uvlo_on_raw),
      .q       (sif.uvlo_on)
   );
   pdct_filter #(.CYC(`PDCT_EVT_FILT_CYC)) u_det (
      .ref_clk (ref_clk),
      .rst     (rst),
      .raw     (det_exit_raw),
      .q       (sif.det_exit)
   );
   pdct_filter #(.CYC(`PDCT_EVT_FILT_CYC)) u_cls (
      .ref_clk (ref_clk),
      .rst     (rst),
      .raw     (class_range_raw),
      .q       (sif.cls)
   );
   pdct_filter #(.CYC(`PDCT_EVT_FILT_CYC)) u_mark (
      .ref_clk (ref_clk),
      .rst     (rst),
      .raw     (mark_range_raw),
      .q       (sif.mark)
   );
   pdct_filter #(.CYC(`PDCT_EVT_FILT_CYC)) u_rst (
      .ref_clk (ref_clk),
      .rst     (rst),
      .raw     (reset_range_raw),
      .q       (sif.rst_rng)
   );

   always_ff @(posedge ref_clk) begin
      pg_s1_reg <= converter_power_good;
      pg_s2_reg <= pg_s1_reg;
   end

   //////////////////////////////////////////////////////////////////////
   // supply gating
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         operating   <= 1'b0;
         bias_enable <= 1'b0;
      end else begin
         operating   <= sif.uvlo_on;
         bias_enable <= sif.det_exit | sif.uvlo_on;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // finger/mark sequence; settles to done or fail once operating, but reset range or loss of det exit still revokes it
   always_ff @(posedge ref_clk) begin
      if (rst || !sif.det_exit) begin
         state_reg   <= PDCT_IDLE;
         fingers_reg <= 2'h0;
      end else if (sif.rst_rng) begin
         state_reg   <= PDCT_FAIL;
         fingers_reg <= 2'h0;
      end else if (!sif.uvlo_on) begin
         case (state_reg)
            PDCT_IDLE, PDCT_MARK: begin
               if (sif.cls) begin
                  state_reg <= PDCT_FINGER;
               end
            end
            PDCT_FINGER: begin
               if (sif.mark) begin
                  state_reg <= PDCT_MARK;
                  if (fingers_reg != 2'h3) begin
                     fingers_reg <= fingers_reg + 2'h1;
                  end
               end
            end
            PDCT_DONE, PDCT_FAIL: begin
               state_reg <= state_reg;
            end
            default: begin
               state_reg <= PDCT_IDLE;
            end
         endcase
      end else if (state_reg == PDCT_MARK && fingers_reg >= 2'(`PDCT_FINGERS_NEEDED)) begin
         state_reg <= PDCT_DONE;
      end else if (state_reg != PDCT_DONE) begin
         state_reg <= PDCT_FAIL;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // open-drain indicator: enable low means pin is pulled to converter ground
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         high_power_grant_indicator_n_o  <= 1'b0;
         high_power_grant_indicator_n_oe <= `PDCT_IND_RESET;
      end else begin
         high_power_grant_indicator_n_o  <= 1'b0;
         // registered run state, so the grant can never lead operating
         high_power_grant_indicator_n_oe <=
            !(state_reg == PDCT_DONE && operating && pg_s2_reg);
      end
   end
endmodule

// *** tb/pdct_tracker_props.sv ***
// port checker for the event tracker
// bound onto pdct_tracker; one clock domain
`timescale 1ns/10ps
module pdct_tracker_props (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic uvlo_on_raw,
   input wire logic det_exit_raw,
   input wire logic converter_power_good,
   input wire logic operating,
   input wire logic bias_enable,
   input wire logic high_power_grant_indicator_n_o,
   input wire logic high_power_grant_indicator_n_oe
);
   wire oe = high_power_grant_indicator_n_oe;
   wire uv = uvlo_on_raw;
   wire de = det_exit_raw;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_od_data: assert property (!high_power_grant_indicator_n_o) else $error("od data");
   chk_rst_idle: assert property (
      $fell(rst) |-> oe && !operating && !bias_enable) else $error("reset state");
   chk_on_filt: assert property (
      $rose(operating) |-> $past(uv, 8) && $past(uv, 40)) else $error("early on");
   chk_off_filt: assert property (
      $fell(operating) |-> !$past(uv, 8) && !$past(uv, 40)) else $error("early off");
   chk_bias_on: assert property ($rose(bias_enable) |-> $past(de, 8)) else $error("bias");
   chk_bias_off: assert property ($fell(bias_enable) |-> !$past(de, 8)) else $error("bias");
   chk_grant_cause: assert property (
      $fell(oe) |-> operating && $past(converter_power_good, 2)) else $error("grant");
   chk_release_why: assert property (
      $rose(oe) |-> !$past(converter_power_good, 2) || !$past(uv, 8) || !$past(de, 8))
      else $error("release");
   cover property ($fell(oe));
   cover property ($rose(operating));
   cover property ($fell(bias_enable));
endmodule
bind pdct_tracker pdct_tracker_props u_props (.*);

// *** tb/pdct_pse_model.sv ***
// far-side source model: drives the line-range levels
// ref_clk comes from the bench
`timescale 1ns/10ps
module pdct_pse_model (
   input  wire logic ref_clk,
   output logic [4:0] lvl
);
   // lvl = {turn-on, det exit, class, mark, reset}
   initial lvl = 5'h00;
   task automatic line(input logic [4:0] v, input int n);
      @(posedge ref_clk);
      #1 lvl = v;
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic finger();
      line(5'h0C, 60);
      line(5'h0A, 60);
   endtask
endmodule

// *** tb/pdct_tracker_tb.sv ***
// self-checking bench for the event tracker
// source model drives line ranges; bench drives power good
`timescale 1ns/10ps
module pdct_tracker_tb;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       pg = 1'b0;
   logic [4:0] lvl;
   logic       op, bias, ind_o, ind_oe;
   int         n_errors = 0;
   int         n_checks = 0;
   always #2 ref_clk = ~ref_clk;
   pdct_pse_model u_pse (.ref_clk(ref_clk), .lvl(lvl));
   pdct_tracker u_dut (.ref_clk(ref_clk), .rst(rst), .uvlo_on_raw(lvl[4]),
      .det_exit_raw(lvl[3]), .class_range_raw(lvl[2]), .mark_range_raw(lvl[1]),
      .reset_range_raw(lvl[0]), .converter_power_good(pg), .operating(op),
      .bias_enable(bias), .high_power_grant_indicator_n_o(ind_o),
      .high_power_grant_indicator_n_oe(ind_oe));
   task automatic check(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t value mismatch", $time);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // classify, power up, grant check, power down
   task automatic session(input int nf, input bit bad, input logic exp);
      u_pse.line(5'h08, 60);
      check(bias, 1'b1);
      repeat (nf) u_pse.finger();
      if (bad) u_pse.line(5'h09, 60);
      u_pse.line(5'h18, 2600);
      check(op, 1'b1);
      pg = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1 check(ind_oe, exp);
      check(ind_o, 1'b0);
      u_pse.line(5'h00, 2600);
      check(ind_oe, 1'b1);
      check(bias, 1'b0);
      pg = 1'b0;
   endtask
   // short turn-on and short drop must both be filtered out
   task automatic uvlo_glitch();
      u_pse.line(5'h18, 100);
      check(op, 1'b0);
      u_pse.line(5'h18, 2600);
      u_pse.line(5'h08, 100);
      u_pse.line(5'h18, 100);
      check(op, 1'b1);
      u_pse.line(5'h00, 2600);
      check(op, 1'b0);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      #1 rst = 1'b0;
      session(0, 1'b0, 1'b1);
      session(1, 1'b0, 1'b1);
      session(2, 1'b0, 1'b0);
      session(3, 1'b0, 1'b0);
      session(2, 1'b1, 1'b1);
      uvlo_glitch();
      final_report();
   end
   initial begin
      #300000;
      n_errors++;
      final_report();
   end
endmodule
